/* cpwm_pkg.sv */
package cpwm_pkg;

	// ==========================================================
	// Bus and register map (byte addresses, one word each)
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam logic [7:0] OFS_CONTROL1 = 8'h00;
	localparam logic [7:0] OFS_CONTROL2 = 8'h04;
	localparam logic [7:0] OFS_DUTY_HIGH1 = 8'h08;
	localparam logic [7:0] OFS_SHADOW1 = 8'h0C;
	localparam logic [7:0] OFS_DUTY_HIGH2 = 8'h10;
	localparam logic [7:0] OFS_SHADOW2 = 8'h14;
	localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h18;
	localparam logic [7:0] OFS_TIMER_CONTROL = 8'h1C;
	localparam logic [7:0] OFS_PERIOD_COUNTER = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_PIN_CONFIG = 8'h28;

	// ==========================================================
	// Field positions
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_LOW_LSB = 4;
	localparam logic [7:0] CTL_WMASK = 8'h3F;
	localparam logic [3:0] MODE_PWM_MASK = 4'hC;
	localparam int TC_PRESC_LSB = 0;
	localparam int TC_RUN_BIT = 2;
	localparam int TC_POST_LSB = 3;
	localparam logic [7:0] TC_WMASK = 8'h7F;
	localparam int ST_FLAG_BIT = 0;
	localparam int PC_SEL_BIT = 0;
	localparam int PC_DIR_LSB = 1;
	localparam int PC_DATA_LSB = 4;
	localparam logic [7:0] PC_WMASK = 8'h7F;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
	localparam logic [7:0] RST_PIN_CONFIG = 8'h0E;

	// ==========================================================
	// Timing: one system clock period, prescaler terminal counts
	localparam int CLK_PERIOD_NS = 100;
	localparam int TB_PHASES = 4;
	localparam logic [5:0] TERM_DIV1 = 6'(TB_PHASES - 1);
	localparam logic [5:0] TERM_DIV4 = 6'(TB_PHASES * 4 - 1);
	localparam logic [5:0] TERM_DIV16 = 6'(TB_PHASES * 16 - 1);

	typedef enum logic [1:0] {
		CPWM_DIV1 = 2'b00,
		CPWM_DIV4 = 2'b01,
		CPWM_DIV16 = 2'b10,
		CPWM_DIV16B = 2'b11
	} cpwm_presc_e;

endpackage

/* cpwm_channel.sv */
module cpwm_channel (
	input wire logic i_clock, // System clock
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic i_hold, // Sleep: freeze state
	input wire logic i_load, // Increment cycle after a period match
	input wire logic i_active, // Mode field selects PWM
	input wire logic [9:0] i_timebase, // Counter with sub-count bits
	input wire logic [7:0] i_duty_high, // Duty high byte register
	input wire logic [1:0] i_duty_low, // Duty low bits from control
	input wire logic i_shadow_we, // Software write to shadow
	input wire logic [7:0] i_shadow_wdata, // Write data for shadow
	output logic [7:0] o_shadow, // Buffered duty high bits
	output logic o_level // PWM waveform
);
	import cpwm_pkg::*;

	logic [1:0] latch_q;
	logic [9:0] duty_new;
	logic level_q;
	logic duty_match;

	assign duty_new = {i_duty_high, i_duty_low};
	assign duty_match = i_timebase == {o_shadow, latch_q}; // [RQ12]
	// Falls in the clock where the time base meets the duty, so high time is duty x prescale clocks
	assign o_level = level_q && !duty_match; // [RQ9] [RQ12] [RQ14]

	// ==========================================================
	// Double buffer of the duty value
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_shadow <= RST_BYTE;
			latch_q <= 2'h0;
		end else if (i_load && !i_hold) begin
			o_shadow <= i_duty_high; // [RQ4] [RQ7] [RQ10]
			latch_q <= i_duty_low; // [RQ6]
		end else if (i_shadow_we && !i_active) begin
			o_shadow <= i_shadow_wdata; // [RQ8]
		end
	end

	// ==========================================================
	// Output level: set at period start, cleared on duty match
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			level_q <= 1'b0;
		end else if (!i_active) begin
			level_q <= 1'b0;
		end else if (i_hold) begin
			level_q <= level_q; // [RQ15]
		end else if (i_load) begin
			level_q <= (duty_new != 10'h000); // [RQ3]
		end else if (duty_match) begin
			level_q <= 1'b0; // [RQ12] [RQ9] [RQ14]
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	property p_load_copy;
		i_load && !i_hold |=> o_shadow == $past(i_duty_high) && latch_q == $past(i_duty_low);
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("duty not latched"); // [RQ4]

	property p_set_start;
		i_load && !i_hold && i_active && duty_new != 10'h000 |=> level_q;
	endproperty
	a_set_start: assert property (p_set_start) else $error("pin not set"); // [RQ3]

	property p_zero_duty;
		i_load && !i_hold && i_active && duty_new == 10'h000 |=> !level_q;
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("zero duty drove high"); // [RQ3]

	property p_clear_match;
		i_active && !i_hold && !i_load && duty_match |=> !level_q;
	endproperty
	a_clear_match: assert property (p_clear_match) else $error("pin not cleared"); // [RQ12]

	property p_buffer_hold;
		!(i_load && !i_hold) && !(i_shadow_we && !i_active) |=> $stable({o_shadow, latch_q});
	endproperty
	a_buffer_hold: assert property (p_buffer_hold) else $error("buffer changed"); // [RQ10]

	property p_shadow_ro;
		i_shadow_we && i_active && !i_load |=> o_shadow == $past(o_shadow);
	endproperty
	a_shadow_ro: assert property (p_shadow_ro) else $error("shadow written"); // [RQ8]

endmodule

/* cpwm_unit.sv */
// What this block does
// RQ1: Period is (limit+1) x 4 x prescale clocks.
// RQ2: Counter clears on increment after limit match.
// RQ3: Pin goes high at period start unless zero.
// RQ4: Duty high byte copied to shadow at start.
// RQ5: Postscale setting never affects the PWM period.
// RQ6: Duty is high byte plus control bits 5:4.
// RQ7: New duty takes effect at next period.
// RQ8: Shadow register is read-only in PWM mode.
// RQ9: High time is duty x clock x prescale.
// RQ10: Shadow plus hidden 2-bit latch double buffer.
// RQ11: Time base is counter plus two sub-count bits.
// RQ12: Pin cleared when time base meets duty.
// RQ13: Resolution is log2 of 4(limit+1) bits.
// RQ14: Duty beyond period leaves pin unchanged.
// RQ15: Sleep freezes counter, state and pin level.
// RQ16: Reset restores registers and makes pins inputs.
// RQ17: Zero control register returns pin to port.
// RQ18: Software clears direction bit to drive pin.
// RQ19: Second unit routes to one of two pins.
// RQ20: Prescale selectable as 1, 4 or 16.
// RQ21: Software follows the documented setup order.
// RQ22: Timer control: run bit 2, prescale 1:0, postscale 6:3.
// RQ23: PWM active only when mode field selects it.
// RQ24: Match flag sets on every period wrap.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
module cpwm_unit (
	input wire logic i_clock, // System clock, 10 MHz
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic i_sleep, // Sleep request, same clock domain
	input wire logic i_wb_cyc, // Wishbone cycle
	input wire logic i_wb_stb, // Wishbone strobe
	input wire logic i_wb_we, // Wishbone write enable
	input wire logic [cpwm_pkg::ADR_W-1:0] i_wb_adr, // Wishbone byte address
	input wire logic [cpwm_pkg::DAT_W-1:0] i_wb_dat, // Wishbone write data
	input wire logic [3:0] i_wb_sel, // Wishbone byte selects
	output logic [cpwm_pkg::DAT_W-1:0] o_wb_dat, // Wishbone read data
	output logic o_wb_ack, // Wishbone acknowledge
	output logic o_pin1, // Unit 1 output pin level
	output logic o_pin1_oe, // Unit 1 output pin enable
	output logic o_pin_def2, // Default pin of unit 2, level
	output logic o_pin_def2_oe, // Default pin of unit 2, enable
	output logic o_pin_alt2, // Alternate pin of unit 2, level
	output logic o_pin_alt2_oe // Alternate pin of unit 2, enable
);
	import cpwm_pkg::*;

	logic [7:0] control1_q;
	logic [7:0] control2_q;
	logic [7:0] duty_high1_q;
	logic [7:0] duty_high2_q;
	logic [7:0] period_limit_q;
	logic [7:0] timer_control_q;
	logic [7:0] period_counter_q;
	logic period_flag_q;
	logic [7:0] pin_config_q;
	logic [5:0] presc_q;
	logic [7:0] shadow1;
	logic [7:0] shadow2;
	logic level1;
	logic level2;
	logic req;
	logic wr;
	logic wr_byte;
	logic timer_run;
	logic tick;
	logic period_start;
	logic [1:0] sub_bits;
	logic [9:0] timebase;
	logic active1;
	logic active2;
	logic [7:0] rd_byte;
	logic [7:0] wdata;

	// ==========================================================
	// Helpers
	function automatic logic [5:0] presc_term(input logic [1:0] sel);
		case (cpwm_presc_e'(sel))
			CPWM_DIV1: presc_term = TERM_DIV1;
			CPWM_DIV4: presc_term = TERM_DIV4;
			default: presc_term = TERM_DIV16;
		endcase
	endfunction

	function automatic logic [1:0] presc_sub(input logic [1:0] sel, input logic [5:0] cnt);
		case (cpwm_presc_e'(sel))
			CPWM_DIV1: presc_sub = cnt[1:0];
			CPWM_DIV4: presc_sub = cnt[3:2];
			default: presc_sub = cnt[5:4];
		endcase
	endfunction

	function automatic logic is_pwm(input logic [7:0] ctl);
		is_pwm = (ctl[CTL_MODE_LSB+:4] & MODE_PWM_MASK) == MODE_PWM_MASK;
	endfunction

	// ==========================================================
	// Bus request decode
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	// Writes land on the edge where the master samples ack
	assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
	assign wr_byte = wr && i_wb_sel[0];
	assign wdata = i_wb_dat[7:0];

	// ==========================================================
	// Time base
	assign timer_run = timer_control_q[TC_RUN_BIT];
	// Postscale bits are stored but never enter the tick path
	assign tick = timer_run && !i_sleep
		&& presc_q == presc_term(timer_control_q[TC_PRESC_LSB+:2]); // [RQ1] [RQ5] [RQ20]
	assign period_start = tick && period_counter_q == period_limit_q; // [RQ2]
	assign sub_bits = presc_sub(timer_control_q[TC_PRESC_LSB+:2], presc_q); // [RQ11]
	// Width of the usable duty range follows from the limit alone
	assign timebase = {period_counter_q, sub_bits}; // [RQ11] [RQ13]
	assign active1 = is_pwm(control1_q); // [RQ23]
	assign active2 = is_pwm(control2_q); // [RQ23]

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			presc_q <= 6'h00;
		end else if (!timer_run || i_sleep) begin
			presc_q <= presc_q; // [RQ15]
		end else if (tick) begin
			presc_q <= 6'h00; // [RQ1]
		end else begin
			presc_q <= presc_q + 6'h01;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			period_counter_q <= RST_BYTE; // [RQ16]
		end else if (wr_byte && i_wb_adr == OFS_PERIOD_COUNTER) begin
			period_counter_q <= wdata;
		end else if (period_start) begin
			period_counter_q <= 8'h00; // [RQ2]
		end else if (tick) begin
			period_counter_q <= period_counter_q + 8'h01;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			period_flag_q <= 1'b0;
		end else if (period_start) begin
			period_flag_q <= 1'b1; // [RQ24]
		end else if (wr_byte && i_wb_adr == OFS_STATUS && wdata[ST_FLAG_BIT]) begin
			period_flag_q <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			control1_q <= RST_CONTROL; // [RQ16]
			control2_q <= RST_CONTROL;
			duty_high1_q <= RST_BYTE;
			duty_high2_q <= RST_BYTE;
			period_limit_q <= RST_PERIOD_LIMIT;
			timer_control_q <= RST_BYTE;
			pin_config_q <= RST_PIN_CONFIG; // [RQ16]
		end else if (wr_byte) begin
			if (i_wb_adr == OFS_CONTROL1) begin
				control1_q <= wdata & CTL_WMASK; // [RQ6]
			end else if (i_wb_adr == OFS_CONTROL2) begin
				control2_q <= wdata & CTL_WMASK;
			end else if (i_wb_adr == OFS_DUTY_HIGH1) begin
				duty_high1_q <= wdata; // [RQ7]
			end else if (i_wb_adr == OFS_DUTY_HIGH2) begin
				duty_high2_q <= wdata;
			end else if (i_wb_adr == OFS_PERIOD_LIMIT) begin
				period_limit_q <= wdata;
			end else if (i_wb_adr == OFS_TIMER_CONTROL) begin
				timer_control_q <= wdata & TC_WMASK; // [RQ22]
			end else if (i_wb_adr == OFS_PIN_CONFIG) begin
				pin_config_q <= wdata & PC_WMASK; // [RQ19]
			end
		end
	end

	// ==========================================================
	// Duty channels
	cpwm_channel u_ch1 (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_hold(i_sleep),
		.i_load(period_start),
		.i_active(active1),
		.i_timebase(timebase),
		.i_duty_high(duty_high1_q),
		.i_duty_low(control1_q[CTL_LOW_LSB+:2]),
		.i_shadow_we(wr_byte && i_wb_adr == OFS_SHADOW1),
		.i_shadow_wdata(wdata),
		.o_shadow(shadow1),
		.o_level(level1)
	);

	cpwm_channel u_ch2 (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_hold(i_sleep),
		.i_load(period_start),
		.i_active(active2),
		.i_timebase(timebase),
		.i_duty_high(duty_high2_q),
		.i_duty_low(control2_q[CTL_LOW_LSB+:2]),
		.i_shadow_we(wr_byte && i_wb_adr == OFS_SHADOW2),
		.i_shadow_wdata(wdata),
		.o_shadow(shadow2),
		.o_level(level2)
	);

	// ==========================================================
	// Pin multiplexer: PWM owns a pin only in PWM mode
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pin1 <= 1'b0;
			o_pin1_oe <= 1'b0; // [RQ16]
			o_pin_def2 <= 1'b0;
			o_pin_def2_oe <= 1'b0;
			o_pin_alt2 <= 1'b0;
			o_pin_alt2_oe <= 1'b0;
		end else begin
			// Direction bit high keeps the driver off
			o_pin1_oe <= !pin_config_q[PC_DIR_LSB]; // [RQ18]
			o_pin_def2_oe <= !pin_config_q[PC_DIR_LSB+1];
			o_pin_alt2_oe <= !pin_config_q[PC_DIR_LSB+2];
			o_pin1 <= active1 ? level1 : pin_config_q[PC_DATA_LSB]; // [RQ17]
			if (active2 && !pin_config_q[PC_SEL_BIT]) begin
				o_pin_def2 <= level2; // [RQ19]
			end else begin
				o_pin_def2 <= pin_config_q[PC_DATA_LSB+1]; // [RQ17]
			end
			if (active2 && pin_config_q[PC_SEL_BIT]) begin
				o_pin_alt2 <= level2; // [RQ19]
			end else begin
				o_pin_alt2 <= pin_config_q[PC_DATA_LSB+2];
			end
		end
	end

	// ==========================================================
	// Read mux and acknowledge
	always_comb begin
		if (i_wb_adr == OFS_CONTROL1) begin
			rd_byte = control1_q;
		end else if (i_wb_adr == OFS_CONTROL2) begin
			rd_byte = control2_q;
		end else if (i_wb_adr == OFS_DUTY_HIGH1) begin
			rd_byte = duty_high1_q;
		end else if (i_wb_adr == OFS_SHADOW1) begin
			rd_byte = shadow1;
		end else if (i_wb_adr == OFS_DUTY_HIGH2) begin
			rd_byte = duty_high2_q;
		end else if (i_wb_adr == OFS_SHADOW2) begin
			rd_byte = shadow2;
		end else if (i_wb_adr == OFS_PERIOD_LIMIT) begin
			rd_byte = period_limit_q;
		end else if (i_wb_adr == OFS_TIMER_CONTROL) begin
			rd_byte = timer_control_q;
		end else if (i_wb_adr == OFS_PERIOD_COUNTER) begin
			rd_byte = period_counter_q;
		end else if (i_wb_adr == OFS_STATUS) begin
			rd_byte = {7'h00, period_flag_q};
		end else if (i_wb_adr == OFS_PIN_CONFIG) begin
			rd_byte = pin_config_q;
		end else begin
			rd_byte = 8'h00;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else begin
			o_wb_ack <= req;
			if (req && !i_wb_we) begin
				o_wb_dat <= {24'h000000, rd_byte};
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	sequence s_tick_div1;
		tick && timer_control_q[TC_PRESC_LSB+:2] == CPWM_DIV1;
	endsequence

	sequence s_run_div1;
		(timer_run && !i_sleep && timer_control_q[TC_PRESC_LSB+:2] == CPWM_DIV1 && !wr)[*4];
	endsequence

	property p_tick_div1;
		s_tick_div1 ##1 s_run_div1 |-> tick && !$past(tick);
	endproperty
	a_tick_div1: assert property (p_tick_div1) else $error("div1 tick spacing wrong"); // [RQ1]

	property p_wrap;
		period_start && !wr |=> period_counter_q == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter not cleared"); // [RQ2]

	property p_flag_set;
		period_start |=> period_flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("match flag not set"); // [RQ24]

	property p_sleep_freeze;
		i_sleep && !wr |=> $stable(period_counter_q) && $stable(presc_q) && $stable(level1);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze) else $error("state moved in sleep"); // [RQ15]

	property p_release;
		control1_q == 8'h00 |=> o_pin1 == $past(pin_config_q[PC_DATA_LSB]);
	endproperty
	a_release: assert property (p_release) else $error("pin not released"); // [RQ17]

	property p_route_alt;
		active2 && pin_config_q[PC_SEL_BIT] |=> o_pin_alt2 == $past(level2);
	endproperty
	a_route_alt: assert property (p_route_alt) else $error("alternate route wrong"); // [RQ19]

	property p_not_pwm;
		!active1 |=> !level1;
	endproperty
	a_not_pwm: assert property (p_not_pwm) else $error("waveform outside PWM mode"); // [RQ23]

	property p_ack_once;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held");

	property p_timer_stop;
		!timer_run && !i_sleep && !wr |=> $stable(period_counter_q) && $stable(presc_q);
	endproperty
	a_timer_stop: assert property (p_timer_stop) else $error("stopped timer moved"); // [RQ22]

	property p_route_def;
		active2 && !pin_config_q[PC_SEL_BIT] |=> o_pin_def2 == $past(level2);
	endproperty
	a_route_def: assert property (p_route_def) else $error("default route wrong"); // [RQ19]

endmodule

/* cpwm_load.sv */
module cpwm_load (
	input wire logic i_clock, // System clock
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic i_drive, // Pin level from the unit
	input wire logic i_drive_oe, // Pin driver enable
	output logic o_level, // Level seen at the load
	output logic [15:0] o_high, // High clocks of the last period
	output logic [15:0] o_period, // Clocks between rising edges
	output logic [15:0] o_rises // Rising edges seen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_q;
	logic [15:0] hcnt_q;
	logic [15:0] pcnt_q;

	// Pull-down at the load takes an undriven line low
	assign o_level = i_drive_oe ? i_drive : 1'b0;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prev_q <= 1'b0;
			hcnt_q <= 16'h0000;
			pcnt_q <= 16'h0000;
			o_high <= 16'h0000;
			o_period <= 16'h0000;
			o_rises <= 16'h0000;
		end else begin
			prev_q <= o_level;
			if (o_level && !prev_q) begin
				o_high <= hcnt_q;
				o_period <= pcnt_q;
				o_rises <= o_rises + 16'h0001;
				hcnt_q <= 16'h0001;
				pcnt_q <= 16'h0001;
			end else begin
				hcnt_q <= hcnt_q + 16'(o_level);
				pcnt_q <= pcnt_q + 16'h0001;
			end
		end
	end
endmodule

/* cpwm_unit_test.sv */
module cpwm_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	import cpwm_pkg::*;
	logic i_clock = 1'b0;
	logic i_sys_rst, i_sleep, i_wb_cyc, i_wb_stb, i_wb_we;
	logic [ADR_W-1:0] i_wb_adr;
	logic [DAT_W-1:0] i_wb_dat;
	logic [3:0] i_wb_sel;
	logic [DAT_W-1:0] o_wb_dat;
	logic o_wb_ack, o_pin1, o_pin1_oe, o_pin_def2, o_pin_def2_oe, o_pin_alt2, o_pin_alt2_oe;
	logic p1_level, p2_level;
	logic [15:0] p1_high, p1_period, p1_rises, p2_high, p2_period, p2_rises, seed;
	int err_count, checked, cycles;

	cpwm_unit u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sleep(i_sleep),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
		.i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.o_pin1(o_pin1), .o_pin1_oe(o_pin1_oe), .o_pin_def2(o_pin_def2),
		.o_pin_def2_oe(o_pin_def2_oe), .o_pin_alt2(o_pin_alt2), .o_pin_alt2_oe(o_pin_alt2_oe));
	cpwm_load u_load1 (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_drive(o_pin1),
		.i_drive_oe(o_pin1_oe), .o_level(p1_level), .o_high(p1_high), .o_period(p1_period),
		.o_rises(p1_rises));
	cpwm_load u_load2 (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_drive(o_pin_alt2),
		.i_drive_oe(o_pin_alt2_oe), .o_level(p2_level), .o_high(p2_high), .o_period(p2_period),
		.o_rises(p2_rises));

	always #50 i_clock = ~i_clock;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int pf(input logic [1:0] ps);
		return (ps == 2'b00) ? 1 : ((ps == 2'b01) ? 4 : 16);
	endfunction

	task automatic complete_run();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic single cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clock);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= {24'h000000, d};
		do begin
			@(posedge i_clock);
			n++;
		end while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		chk(32'(n), 32'h2);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 8'h00, q);
	endtask

	task automatic wait_flag();
		logic [31:0] q;
		int n;
		n = 0;
		wr(OFS_STATUS, 8'h01);
		do begin
			rd(OFS_STATUS, q);
			n++;
		end while (q[ST_FLAG_BIT] !== 1'b1 && n < 1000);
		chk(q, 32'h1);
	endtask

	task automatic wait_rises(input logic alt, input int n);
		logic [15:0] r0;
		int c;
		r0 = alt ? p2_rises : p1_rises;
		c = 0;
		while ((alt ? p2_rises : p1_rises) - r0 < 16'(n) && c < 5000) begin
			@(posedge i_clock);
			c++;
		end
		chk(32'(c < 5000), 32'h1);
	endtask

	task automatic no_rise(input logic lv_exp);
		logic [15:0] r0;
		wait_flag();
		repeat (3) @(posedge i_clock);
		r0 = p1_rises;
		wait_flag();
		wait_flag();
		chk({p1_rises, 15'h0000, p1_level}, {r0, 15'h0000, lv_exp});
	endtask

	task automatic pwm_setup(input logic [7:0] lim, input logic [9:0] duty, input logic [7:0] tc);
		logic [31:0] q;
		wr(OFS_TIMER_CONTROL, 8'h00);
		wr(OFS_PERIOD_COUNTER, 8'h00);
		wr(OFS_PIN_CONFIG, 8'h0E);
		wr(OFS_PERIOD_LIMIT, lim);
		wr(OFS_CONTROL1, {2'b00, duty[1:0], 4'hC});
		wr(OFS_DUTY_HIGH1, duty[9:2]);
		wr(OFS_STATUS, 8'h01);
		rd(OFS_STATUS, q);
		chk(q, 32'h0);
		wr(OFS_TIMER_CONTROL, tc);
		wait_flag();
		wr(OFS_PIN_CONFIG, 8'h0C);
	endtask

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			$display("Timeout at t=%0t", $time);
			complete_run();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] q, q2;
		logic [7:0] lim;
		logic [9:0] duty;
		logic [1:0] ps;
		logic [15:0] r0;
		logic lv;
		int hc;
		{i_sys_rst, i_sleep, i_wb_cyc, i_wb_stb, i_wb_we} = 5'b10000;
		i_wb_adr = 8'h00;
		i_wb_dat = 32'h00000000;
		i_wb_sel = 4'hF;
		seed = 16'hA1E4;
		repeat (12) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		rd(OFS_CONTROL1, q);
		chk(q, {24'h000000, RST_CONTROL});
		rd(OFS_TIMER_CONTROL, q);
		chk(q, 32'h0);
		rd(OFS_PERIOD_LIMIT, q);
		chk(q, {24'h000000, RST_PERIOD_LIMIT});
		rd(OFS_PIN_CONFIG, q);
		chk(q, {24'h000000, RST_PIN_CONFIG});
		chk({29'h0, o_pin1_oe, o_pin_def2_oe, o_pin_alt2_oe}, 32'h0);
		rd(8'h3C, q);
		chk(q, 32'h0);
		$display("done: reset");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			ps = 2'(i % 4);
			lim = {5'h00, seed[2:0]};
			duty = 10'(1 + int'(seed[15:6]) % (4 * (int'(lim) + 1) - 1));
			pwm_setup(lim, duty, {1'b0, seed[6:3], 1'b1, ps});
			wait_rises(1'b0, 3);
			chk({16'h0, p1_period}, 32'((int'(lim) + 1) * 4 * pf(ps)));
			chk({16'h0, p1_high}, 32'(int'(duty) * pf(ps)));
		end
		$display("done: periods");
		wait_flag();
		rd(OFS_SHADOW1, q);
		wr(OFS_DUTY_HIGH1, ~q[7:0]);
		rd(OFS_SHADOW1, q2);
		chk(q2, q);
		wr(OFS_SHADOW1, 8'h5A);
		rd(OFS_SHADOW1, q2);
		chk(q2, q);
		wait_flag();
		rd(OFS_SHADOW1, q2);
		chk(q2, {24'h000000, ~q[7:0]});
		wr(OFS_DUTY_HIGH1, 8'hFF);
		no_rise(1'b1);
		wr(OFS_CONTROL1, 8'h0C);
		wr(OFS_DUTY_HIGH1, 8'h00);
		no_rise(1'b0);
		$display("done: duty edges");
		wr(OFS_PERIOD_LIMIT, 8'h03);
		wr(OFS_PERIOD_COUNTER, 8'h00);
		wr(OFS_DUTY_HIGH1, 8'h01);
		wait_rises(1'b0, 2);
		@(posedge i_clock);
		i_sleep <= 1'b1;
		rd(OFS_PERIOD_COUNTER, q);
		lv = p1_level;
		repeat (100) @(posedge i_clock);
		rd(OFS_PERIOD_COUNTER, q2);
		chk(q2, q);
		chk({31'h0, p1_level}, {31'h0, lv});
		i_sleep <= 1'b0;
		wait_rises(1'b0, 2);
		$display("done: sleep");
		wr(OFS_CONTROL1, 8'h00);
		wr(OFS_PIN_CONFIG, 8'h1C);
		repeat (3) @(posedge i_clock);
		chk({30'h0, o_pin1_oe, o_pin1}, 32'h3);
		wr(OFS_PIN_CONFIG, 8'h0C);
		repeat (3) @(posedge i_clock);
		chk({30'h0, o_pin1_oe, o_pin1}, 32'h2);
		$display("done: release");
		wr(OFS_CONTROL2, 8'h2C);
		wr(OFS_DUTY_HIGH2, 8'h01);
		wr(OFS_PIN_CONFIG, 8'h01);
		wait_rises(1'b1, 3);
		chk({16'h0, p2_high}, 32'(6 * pf(ps)));
		chk({16'h0, p2_period}, 32'(16 * pf(ps)));
		wr(OFS_PIN_CONFIG, 8'h00);
		repeat (3) @(posedge i_clock);
		r0 = p2_rises;
		hc = 0;
		repeat (512) begin
			@(posedge i_clock);
			hc += int'(o_pin_def2);
		end
		chk({o_pin_def2_oe, 31'(hc)}, {1'b1, 31'(2 * 6 * pf(ps))});
		chk({p2_rises, 15'h0000, p2_level}, {r0, 16'h0000});
		$display("done: second unit");
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		chk({29'h0, o_pin1_oe, o_pin_def2_oe, o_pin_alt2_oe}, 32'h0);
		rd(OFS_SHADOW2, q);
		chk(q, {24'h000000, RST_BYTE});
		rd(OFS_PERIOD_LIMIT, q);
		chk(q, {24'h000000, RST_PERIOD_LIMIT});
		$display("done: reset again");
		complete_run();
	end
endmodule
